// File: anr_data_regs.sv
//==============================================================================
// Purpose: read-only attitude, position, velocity and receiver data bank
// Assumes: producers on mclk_i; AXI4-Lite slave, 32-bit data
// Notes:   each word is loaded whole from one update strobe
//==============================================================================
`timescale 1ns/1ps

module anr_data_regs #(
   parameter int ADDR_W = 12
) (
   // clock and reset
   input wire logic mclk_i,
   input wire logic sys_rst_i,
   // euler estimates from the filter
   input wire logic euler_upd_i,
   input wire logic [15:0] roll_i,
   input wire logic [15:0] pitch_i,
   input wire logic [15:0] yaw_i,
   input wire logic [15:0] roll_rate_i,
   input wire logic [15:0] pitch_rate_i,
   input wire logic [15:0] yaw_rate_i,
   input wire logic [31:0] euler_time_i,
   // position relative to home, from the filter
   input wire logic pos_upd_i,
   input wire logic [31:0] pos_north_i,
   input wire logic [31:0] pos_east_i,
   input wire logic [31:0] pos_alt_i,
   input wire logic [31:0] pos_time_i,
   // velocity from the filter
   input wire logic vel_upd_i,
   input wire logic [31:0] vel_north_i,
   input wire logic [31:0] vel_east_i,
   input wire logic [31:0] vel_vert_i,
   input wire logic [31:0] vel_time_i,
   // receiver report
   input wire logic rx_upd_i,
   input wire logic [31:0] rx_lat_i,
   input wire logic [31:0] rx_lon_i,
   input wire logic [31:0] rx_alt_i,
   input wire logic [31:0] rx_course_i,
   input wire logic [31:0] rx_speed_i,
   input wire logic [31:0] rx_time_i,
   input wire logic [7:0] sat1_id_i,
   input wire logic [7:0] sat1_snr_i,
   input wire logic [7:0] sat2_id_i,
   input wire logic [7:0] sat2_snr_i,
   // axi4-lite write address and data
   input wire logic [ADDR_W-1:0] s_axi_awaddr_i,
   input wire logic s_axi_awvalid_i,
   output logic s_axi_awready_o,
   input wire logic [31:0] s_axi_wdata_i,
   input wire logic [3:0] s_axi_wstrb_i,
   input wire logic s_axi_wvalid_i,
   output logic s_axi_wready_o,
   // axi4-lite write response
   output logic [1:0] s_axi_bresp_o,
   output logic s_axi_bvalid_o,
   input wire logic s_axi_bready_i,
   // axi4-lite read
   input wire logic [ADDR_W-1:0] s_axi_araddr_i,
   input wire logic s_axi_arvalid_i,
   output logic s_axi_arready_o,
   output logic [31:0] s_axi_rdata_o,
   output logic [1:0] s_axi_rresp_o,
   output logic s_axi_rvalid_o,
   input wire logic s_axi_rready_i
);
   import anr_pkg::*;

   //===========================================================================
   // address decode helpers
   function automatic logic [7:0] word_idx(input logic [ADDR_W-1:0] addr);
      word_idx = 8'(addr[ADDR_W-1:2]);
   endfunction

   function automatic logic word_mapped(input logic [ADDR_W-1:0] addr);
      logic [ADDR_W-3:0] w;
      w = addr[ADDR_W-1:2];
      word_mapped = (addr[1:0] == 2'h0) && (w >= (ADDR_W-2)'(ANR_IDX_FIRST))
                    && (w <= (ADDR_W-2)'(ANR_IDX_LAST));
   endfunction

   //===========================================================================
   // data store
   logic [31:0] store_r [ANR_IDX_FIRST:ANR_IDX_LAST];
   logic [31:0] store_nxt [ANR_IDX_FIRST:ANR_IDX_LAST];

   // load whole words from each producer strobe, never from the bus
   always_comb begin
      store_nxt = store_r;
      if (euler_upd_i) begin
         store_nxt[ANR_IDX_ROLL_PITCH] = {roll_i, pitch_i};
         store_nxt[ANR_IDX_YAW] = {yaw_i, ANR_UNUSED_HALF};
         store_nxt[ANR_IDX_ROLL_PITCH_RATE] = {roll_rate_i, pitch_rate_i};
         store_nxt[ANR_IDX_YAW_RATE] = {yaw_rate_i, ANR_UNUSED_HALF};
         store_nxt[ANR_IDX_EULER_TIME] = euler_time_i;
      end
      if (pos_upd_i) begin
         store_nxt[ANR_IDX_POS_NORTH] = pos_north_i;
         store_nxt[ANR_IDX_POS_EAST] = pos_east_i;
         store_nxt[ANR_IDX_POS_ALT] = pos_alt_i;
         store_nxt[ANR_IDX_POS_TIME] = pos_time_i;
      end
      if (vel_upd_i) begin
         store_nxt[ANR_IDX_VEL_NORTH] = vel_north_i;
         store_nxt[ANR_IDX_VEL_EAST] = vel_east_i;
         store_nxt[ANR_IDX_VEL_VERT] = vel_vert_i;
         store_nxt[ANR_IDX_VEL_TIME] = vel_time_i;
      end
      if (rx_upd_i) begin
         store_nxt[ANR_IDX_RX_LAT] = rx_lat_i;
         store_nxt[ANR_IDX_RX_LON] = rx_lon_i;
         store_nxt[ANR_IDX_RX_ALT] = rx_alt_i;
         store_nxt[ANR_IDX_RX_COURSE] = rx_course_i;
         store_nxt[ANR_IDX_RX_SPEED] = rx_speed_i;
         store_nxt[ANR_IDX_RX_TIME] = rx_time_i;
         store_nxt[ANR_IDX_SATS_1_2] = {sat1_id_i, sat1_snr_i, sat2_id_i, sat2_snr_i};
      end
   end

   // register the store
   always_ff @(posedge mclk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         for (int i = ANR_IDX_FIRST; i <= ANR_IDX_LAST; i++) begin
            store_r[i] <= ANR_WORD_RST;
         end
      end else begin
         store_r <= store_nxt;
      end
   end

   //===========================================================================
   // read channel
   anr_rd_state_e rd_state_r, rd_state_nxt;
   logic arready_r, arready_nxt;
   logic rvalid_r, rvalid_nxt;
   logic [31:0] rdata_r, rdata_nxt;
   logic [1:0] rresp_r, rresp_nxt;

   // whole word snapshot at address handshake
   always_comb begin
      rd_state_nxt = rd_state_r;
      arready_nxt = arready_r;
      rvalid_nxt = rvalid_r;
      rdata_nxt = rdata_r;
      rresp_nxt = rresp_r;
      case (rd_state_r)
         ANR_RD_IDLE: begin
            if (s_axi_arvalid_i && arready_r) begin
               rd_state_nxt = ANR_RD_RESP;
               arready_nxt = 1'b0;
               rvalid_nxt = 1'b1;
               if (word_mapped(s_axi_araddr_i)) begin
                  rdata_nxt = store_r[word_idx(s_axi_araddr_i)];
                  rresp_nxt = ANR_RESP_OKAY;
               end else begin
                  rdata_nxt = ANR_WORD_RST;
                  rresp_nxt = ANR_RESP_SLVERR;
               end
            end
         end
         ANR_RD_RESP: begin
            if (s_axi_rready_i) begin
               rd_state_nxt = ANR_RD_IDLE;
               arready_nxt = 1'b1;
               rvalid_nxt = 1'b0;
            end
         end
         default: begin
            rd_state_nxt = ANR_RD_IDLE;
            arready_nxt = 1'b1;
            rvalid_nxt = 1'b0;
         end
      endcase
   end

   // register read channel
   always_ff @(posedge mclk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         rd_state_r <= ANR_RD_IDLE;
         arready_r <= 1'b1;
         rvalid_r <= 1'b0;
         rdata_r <= ANR_WORD_RST;
         rresp_r <= ANR_RESP_OKAY;
      end else begin
         rd_state_r <= rd_state_nxt;
         arready_r <= arready_nxt;
         rvalid_r <= rvalid_nxt;
         rdata_r <= rdata_nxt;
         rresp_r <= rresp_nxt;
      end
   end

   //===========================================================================
   // write channel: accepted and answered, stores nothing
   anr_wr_state_e wr_state_r, wr_state_nxt;
   logic awready_r, awready_nxt;
   logic wready_r, wready_nxt;
   logic aw_got_r, aw_got_nxt;
   logic w_got_r, w_got_nxt;
   logic [ADDR_W-1:0] awaddr_r, awaddr_nxt;
   logic bvalid_r, bvalid_nxt;
   logic [1:0] bresp_r, bresp_nxt;
   logic aw_now, w_now;
   logic [ADDR_W-1:0] addr_now;

   // address and data taken in either order
   always_comb begin
      wr_state_nxt = wr_state_r;
      awready_nxt = awready_r;
      wready_nxt = wready_r;
      aw_got_nxt = aw_got_r;
      w_got_nxt = w_got_r;
      awaddr_nxt = awaddr_r;
      bvalid_nxt = bvalid_r;
      bresp_nxt = bresp_r;
      aw_now = aw_got_r || (s_axi_awvalid_i && awready_r);
      w_now = w_got_r || (s_axi_wvalid_i && wready_r);
      addr_now = aw_got_r ? awaddr_r : s_axi_awaddr_i;
      case (wr_state_r)
         ANR_WR_IDLE: begin
            if (aw_now && w_now) begin
               wr_state_nxt = ANR_WR_RESP;
               awready_nxt = 1'b0;
               wready_nxt = 1'b0;
               aw_got_nxt = 1'b0;
               w_got_nxt = 1'b0;
               bvalid_nxt = 1'b1;
               // mapped words are read-only: okay but no effect
               bresp_nxt = word_mapped(addr_now) ? ANR_RESP_OKAY : ANR_RESP_SLVERR;
            end else begin
               if (aw_now && !aw_got_r) begin
                  aw_got_nxt = 1'b1;
                  awaddr_nxt = s_axi_awaddr_i;
                  awready_nxt = 1'b0;
               end
               if (w_now && !w_got_r) begin
                  w_got_nxt = 1'b1;
                  wready_nxt = 1'b0;
               end
            end
         end
         ANR_WR_RESP: begin
            if (s_axi_bready_i) begin
               wr_state_nxt = ANR_WR_IDLE;
               bvalid_nxt = 1'b0;
               awready_nxt = 1'b1;
               wready_nxt = 1'b1;
            end
         end
         default: begin
            wr_state_nxt = ANR_WR_IDLE;
            bvalid_nxt = 1'b0;
            awready_nxt = 1'b1;
            wready_nxt = 1'b1;
            aw_got_nxt = 1'b0;
            w_got_nxt = 1'b0;
         end
      endcase
   end

   // register write channel
   always_ff @(posedge mclk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         wr_state_r <= ANR_WR_IDLE;
         awready_r <= 1'b1;
         wready_r <= 1'b1;
         aw_got_r <= 1'b0;
         w_got_r <= 1'b0;
         awaddr_r <= '0;
         bvalid_r <= 1'b0;
         bresp_r <= ANR_RESP_OKAY;
      end else begin
         wr_state_r <= wr_state_nxt;
         awready_r <= awready_nxt;
         wready_r <= wready_nxt;
         aw_got_r <= aw_got_nxt;
         w_got_r <= w_got_nxt;
         awaddr_r <= awaddr_nxt;
         bvalid_r <= bvalid_nxt;
         bresp_r <= bresp_nxt;
      end
   end

   //===========================================================================
   // outputs straight from flops
   assign s_axi_awready_o = awready_r;
   assign s_axi_wready_o = wready_r;
   assign s_axi_bvalid_o = bvalid_r;
   assign s_axi_bresp_o = bresp_r;
   assign s_axi_arready_o = arready_r;
   assign s_axi_rvalid_o = rvalid_r;
   assign s_axi_rdata_o = rdata_r;
   assign s_axi_rresp_o = rresp_r;

   //===========================================================================
   // checks
   property p_roll_pitch;
      @(posedge mclk_i) disable iff (sys_rst_i)
      euler_upd_i |=> store_r[ANR_IDX_ROLL_PITCH] == {$past(roll_i), $past(pitch_i)};
   endproperty
   a_roll_pitch: assert property (p_roll_pitch) else $error("roll/pitch word wrong");

   property p_yaw;
      @(posedge mclk_i) disable iff (sys_rst_i)
      euler_upd_i |=> store_r[ANR_IDX_YAW][ANR_HI_MSB:ANR_HI_LSB] == $past(yaw_i);
   endproperty
   a_yaw: assert property (p_yaw) else $error("yaw half wrong");

   property p_unused_low;
      @(posedge mclk_i) disable iff (sys_rst_i)
      store_r[ANR_IDX_YAW][ANR_LO_MSB:ANR_LO_LSB] == ANR_UNUSED_HALF
      && store_r[ANR_IDX_YAW_RATE][ANR_LO_MSB:ANR_LO_LSB] == ANR_UNUSED_HALF;
   endproperty
   a_unused_low: assert property (p_unused_low) else $error("unused half not zero");

   property p_rates;
      @(posedge mclk_i) disable iff (sys_rst_i)
      euler_upd_i |=> store_r[ANR_IDX_ROLL_PITCH_RATE] == {$past(roll_rate_i), $past(pitch_rate_i)}
      && store_r[ANR_IDX_YAW_RATE][ANR_HI_MSB:ANR_HI_LSB] == $past(yaw_rate_i);
   endproperty
   a_rates: assert property (p_rates) else $error("rate words wrong");

   property p_euler_time;
      @(posedge mclk_i) disable iff (sys_rst_i)
      euler_upd_i |=> store_r[ANR_IDX_EULER_TIME] == $past(euler_time_i);
   endproperty
   a_euler_time: assert property (p_euler_time) else $error("euler time wrong");

   property p_position;
      @(posedge mclk_i) disable iff (sys_rst_i)
      pos_upd_i |=> store_r[ANR_IDX_POS_NORTH] == $past(pos_north_i)
      && store_r[ANR_IDX_POS_EAST] == $past(pos_east_i)
      && store_r[ANR_IDX_POS_ALT] == $past(pos_alt_i)
      && store_r[ANR_IDX_POS_TIME] == $past(pos_time_i);
   endproperty
   a_position: assert property (p_position) else $error("position words wrong");

   property p_velocity;
      @(posedge mclk_i) disable iff (sys_rst_i)
      vel_upd_i |=> store_r[ANR_IDX_VEL_NORTH] == $past(vel_north_i)
      && store_r[ANR_IDX_VEL_EAST] == $past(vel_east_i)
      && store_r[ANR_IDX_VEL_VERT] == $past(vel_vert_i)
      && store_r[ANR_IDX_VEL_TIME] == $past(vel_time_i);
   endproperty
   a_velocity: assert property (p_velocity) else $error("velocity words wrong");

   property p_receiver;
      @(posedge mclk_i) disable iff (sys_rst_i)
      rx_upd_i |=> store_r[ANR_IDX_RX_LAT] == $past(rx_lat_i)
      && store_r[ANR_IDX_RX_LON] == $past(rx_lon_i)
      && store_r[ANR_IDX_RX_ALT] == $past(rx_alt_i)
      && store_r[ANR_IDX_RX_COURSE] == $past(rx_course_i)
      && store_r[ANR_IDX_RX_SPEED] == $past(rx_speed_i)
      && store_r[ANR_IDX_RX_TIME] == $past(rx_time_i);
   endproperty
   a_receiver: assert property (p_receiver) else $error("receiver words wrong");

   property p_sats;
      @(posedge mclk_i) disable iff (sys_rst_i)
      rx_upd_i |=> store_r[ANR_IDX_SATS_1_2][31:24] == $past(sat1_id_i)
      && store_r[ANR_IDX_SATS_1_2][23:16] == $past(sat1_snr_i)
      && store_r[ANR_IDX_SATS_1_2][15:8] == $past(sat2_id_i)
      && store_r[ANR_IDX_SATS_1_2][7:0] == $past(sat2_snr_i);
   endproperty
   a_sats: assert property (p_sats) else $error("satellite bytes wrong");

   property p_hold;
      @(posedge mclk_i) disable iff (sys_rst_i)
      !euler_upd_i |=> $stable(store_r[ANR_IDX_ROLL_PITCH]);
   endproperty
   a_hold: assert property (p_hold) else $error("word changed without update");

   property p_read_word;
      @(posedge mclk_i) disable iff (sys_rst_i)
      (s_axi_arvalid_i && arready_r && word_mapped(s_axi_araddr_i))
      |=> rvalid_r && rresp_r == ANR_RESP_OKAY
      && rdata_r == $past(store_r[word_idx(s_axi_araddr_i)]);
   endproperty
   a_read_word: assert property (p_read_word) else $error("read data not one snapshot");

   // write answered exactly one cycle after both halves are taken
   property p_write_answer;
      @(posedge mclk_i) disable iff (sys_rst_i)
      (wr_state_r == ANR_WR_IDLE && aw_now && w_now) |=> bvalid_r && !awready_r && !wready_r;
   endproperty
   a_write_answer: assert property (p_write_answer) else $error("write answer late");

endmodule

// File: anr_pkg.sv
//==============================================================================
// Purpose: constants for the attitude and navigation data register bank
// Assumes: word indices as printed; byte address is four times the index
// Notes:   all data words are read-only; reset value of every word is zero
//==============================================================================
package anr_pkg;

   //===========================================================================
   // register word indices
   localparam logic [7:0] ANR_IDX_FIRST = 8'h70;
   localparam logic [7:0] ANR_IDX_ROLL_PITCH = 8'h70;
   localparam logic [7:0] ANR_IDX_YAW = 8'h71;
   localparam logic [7:0] ANR_IDX_ROLL_PITCH_RATE = 8'h72;
   localparam logic [7:0] ANR_IDX_YAW_RATE = 8'h73;
   localparam logic [7:0] ANR_IDX_EULER_TIME = 8'h74;
   localparam logic [7:0] ANR_IDX_POS_NORTH = 8'h75;
   localparam logic [7:0] ANR_IDX_POS_EAST = 8'h76;
   localparam logic [7:0] ANR_IDX_POS_ALT = 8'h77;
   localparam logic [7:0] ANR_IDX_POS_TIME = 8'h78;
   localparam logic [7:0] ANR_IDX_VEL_NORTH = 8'h79;
   localparam logic [7:0] ANR_IDX_VEL_EAST = 8'h7a;
   localparam logic [7:0] ANR_IDX_VEL_VERT = 8'h7b;
   localparam logic [7:0] ANR_IDX_VEL_TIME = 8'h7c;
   localparam logic [7:0] ANR_IDX_RX_LAT = 8'h7d;
   localparam logic [7:0] ANR_IDX_RX_LON = 8'h7e;
   localparam logic [7:0] ANR_IDX_RX_ALT = 8'h7f;
   localparam logic [7:0] ANR_IDX_RX_COURSE = 8'h80;
   localparam logic [7:0] ANR_IDX_RX_SPEED = 8'h81;
   localparam logic [7:0] ANR_IDX_RX_TIME = 8'h82;
   localparam logic [7:0] ANR_IDX_SATS_1_2 = 8'h83;
   localparam logic [7:0] ANR_IDX_LAST = 8'h83;

   //===========================================================================
   // field positions and reset values
   localparam int ANR_HI_MSB = 31;
   localparam int ANR_HI_LSB = 16;
   localparam int ANR_LO_MSB = 15;
   localparam int ANR_LO_LSB = 0;
   localparam logic [15:0] ANR_UNUSED_HALF = 16'h0000;
   localparam logic [31:0] ANR_WORD_RST = 32'h0000_0000;

   //===========================================================================
   // bus responses
   localparam logic [1:0] ANR_RESP_OKAY = 2'h0;
   localparam logic [1:0] ANR_RESP_SLVERR = 2'h2;

   typedef enum logic [1:0] {
      ANR_RD_IDLE = 2'b01,
      ANR_RD_RESP = 2'b10
   } anr_rd_state_e;

   typedef enum logic [1:0] {
      ANR_WR_IDLE = 2'b01,
      ANR_WR_RESP = 2'b10
   } anr_wr_state_e;

endpackage

// File: anr_host_model.sv
//==========================================================
// Purpose: host model reading the data bank over axi4-lite
// Assumes: one read and one write at most under way
// Notes:   released address and data lines show inverted values
//==========================================================
`timescale 1ns/1ps
module anr_host_model (
   // clock
   input wire logic clk_i,
   // write channels
   output logic [11:0] awaddr_o = 12'h000,
   output logic awvalid_o = 1'b0,
   input wire logic awready_i,
   output logic [31:0] wdata_o = 32'h0000_0000,
   output logic [3:0] wstrb_o = 4'h0,
   output logic wvalid_o = 1'b0,
   input wire logic wready_i,
   input wire logic [1:0] bresp_i,
   input wire logic bvalid_i,
   output logic bready_o = 1'b0,
   // read channels
   output logic [11:0] araddr_o = 12'h000,
   output logic arvalid_o = 1'b0,
   input wire logic arready_i,
   input wire logic [31:0] rdata_i,
   input wire logic [1:0] rresp_i,
   input wire logic rvalid_i,
   output logic rready_o = 1'b0
);
   //==========================================================
   // one read: address held until taken, rready until rvalid
   task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
      @(posedge clk_i);
      araddr_o <= a;
      arvalid_o <= 1'b1;
      rready_o <= 1'b1;
      do @(posedge clk_i); while (arready_i !== 1'b1);
      arvalid_o <= 1'b0;
      araddr_o <= ~a;
      do @(posedge clk_i); while (rvalid_i !== 1'b1);
      d = rdata_i;
      r = rresp_i;
      rready_o <= 1'b0;
   endtask

   // one write: address and data released each when taken
   task automatic wr(input logic [11:0] a, input logic [31:0] v, output logic [1:0] r);
      logic aw_done;
      logic w_done;
      aw_done = 1'b0;
      w_done = 1'b0;
      @(posedge clk_i);
      awaddr_o <= a;
      awvalid_o <= 1'b1;
      wdata_o <= v;
      wstrb_o <= 4'hf;
      wvalid_o <= 1'b1;
      bready_o <= 1'b1;
      while (!(aw_done && w_done)) begin
         @(posedge clk_i);
         if (!aw_done && awready_i === 1'b1) begin
            aw_done = 1'b1;
            awvalid_o <= 1'b0;
            awaddr_o <= ~a;
         end
         if (!w_done && wready_i === 1'b1) begin
            w_done = 1'b1;
            wvalid_o <= 1'b0;
            wdata_o <= ~v;
         end
      end
      do @(posedge clk_i); while (bvalid_i !== 1'b1);
      r = bresp_i;
      bready_o <= 1'b0;
   endtask
endmodule

// File: anr_data_regs_tb_top.sv
//==========================================================
// Purpose: self-checking bench for the data register bank
// Assumes: host model on the bus, bench drives the producers
// Notes:   groups loaded plain then inverted, all words rescanned
//==========================================================
`timescale 1ns/1ps
module anr_data_regs_tb_top;
   import anr_pkg::*;
   typedef struct packed {
      logic [7:0] idx;
      logic [31:0] inp;
      logic [31:0] exp;
   } anr_row_s;
   //==========================================================
   // signals
   logic mclk_i, sys_rst_i, euler_upd_i, pos_upd_i, vel_upd_i, rx_upd_i;
   logic [15:0] roll_i, pitch_i, yaw_i, roll_rate_i, pitch_rate_i, yaw_rate_i;
   logic [31:0] euler_time_i, pos_north_i, pos_east_i, pos_alt_i, pos_time_i;
   logic [31:0] vel_north_i, vel_east_i, vel_vert_i, vel_time_i, rx_lat_i, rx_lon_i;
   logic [31:0] rx_alt_i, rx_course_i, rx_speed_i, rx_time_i, s_axi_wdata_i, s_axi_rdata_o;
   logic [7:0] sat1_id_i, sat1_snr_i, sat2_id_i, sat2_snr_i;
   logic [11:0] s_axi_awaddr_i, s_axi_araddr_i;
   logic [3:0] s_axi_wstrb_i;
   logic [1:0] s_axi_bresp_o, s_axi_rresp_o, rd_r;
   logic s_axi_awvalid_i, s_axi_awready_o, s_axi_wvalid_i, s_axi_wready_o, s_axi_bvalid_o;
   logic s_axi_bready_i, s_axi_arvalid_i, s_axi_arready_o, s_axi_rvalid_o, s_axi_rready_i;
   logic [31:0] rd_d;
   logic [31:0] model [20];
   logic [11:0] bad [3] = '{12'h1bc, 12'h210, 12'h1c2};
   anr_row_s rows [20];
   int err_total = 0;
   int comparisons = 0;
   int cycles = 0;

   //==========================================================
   // design and host
   anr_data_regs #(.ADDR_W(12)) DUT (.*);
   anr_host_model HOST (
      .clk_i(mclk_i), .awaddr_o(s_axi_awaddr_i), .awvalid_o(s_axi_awvalid_i),
      .awready_i(s_axi_awready_o), .wdata_o(s_axi_wdata_i), .wstrb_o(s_axi_wstrb_i),
      .wvalid_o(s_axi_wvalid_i), .wready_i(s_axi_wready_o), .bresp_i(s_axi_bresp_o),
      .bvalid_i(s_axi_bvalid_o), .bready_o(s_axi_bready_i), .araddr_o(s_axi_araddr_i),
      .arvalid_o(s_axi_arvalid_i), .arready_i(s_axi_arready_o), .rdata_i(s_axi_rdata_o),
      .rresp_i(s_axi_rresp_o), .rvalid_i(s_axi_rvalid_o), .rready_o(s_axi_rready_i)
   );

   //==========================================================
   // helpers
   task automatic end_of_test();
      $display("comparisons %0d err_total %0d", comparisons, err_total);
      if (err_total == 0 && comparisons > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      comparisons++;
      if (g !== e) begin
         err_total++;
         $display("MISMATCH %s expected %h seen %h", n, e, g);
      end
   endtask

   function automatic int grp(input int i);
      return (i < 5) ? 0 : (i < 9) ? 1 : (i < 13) ? 2 : 3;
   endfunction

   // expected word after loading with mask m; unused halves stay zero
   function automatic logic [31:0] expw(input int i, input logic [31:0] m);
      logic [31:0] e;
      e = rows[i].exp ^ m;
      if (rows[i].idx == ANR_IDX_YAW || rows[i].idx == ANR_IDX_YAW_RATE) begin
         e[15:0] = ANR_UNUSED_HALF;
      end
      return e;
   endfunction

   // present every producer value, xor mask m
   task automatic apply(input logic [31:0] m);
      roll_i <= rows[0].inp[31:16] ^ m[31:16];
      pitch_i <= rows[0].inp[15:0] ^ m[15:0];
      yaw_i <= rows[1].inp[31:16] ^ m[31:16];
      roll_rate_i <= rows[2].inp[31:16] ^ m[31:16];
      pitch_rate_i <= rows[2].inp[15:0] ^ m[15:0];
      yaw_rate_i <= rows[3].inp[31:16] ^ m[31:16];
      euler_time_i <= rows[4].inp ^ m;
      pos_north_i <= rows[5].inp ^ m;
      pos_east_i <= rows[6].inp ^ m;
      pos_alt_i <= rows[7].inp ^ m;
      pos_time_i <= rows[8].inp ^ m;
      vel_north_i <= rows[9].inp ^ m;
      vel_east_i <= rows[10].inp ^ m;
      vel_vert_i <= rows[11].inp ^ m;
      vel_time_i <= rows[12].inp ^ m;
      rx_lat_i <= rows[13].inp ^ m;
      rx_lon_i <= rows[14].inp ^ m;
      rx_alt_i <= rows[15].inp ^ m;
      rx_course_i <= rows[16].inp ^ m;
      rx_speed_i <= rows[17].inp ^ m;
      rx_time_i <= rows[18].inp ^ m;
      {sat1_id_i, sat1_snr_i, sat2_id_i, sat2_snr_i} <= rows[19].inp ^ m;
   endtask

   // one update pulse for group g only
   task automatic pulse(input int g, input logic [31:0] m);
      @(posedge mclk_i);
      apply(m);
      euler_upd_i <= (g == 0);
      pos_upd_i <= (g == 1);
      vel_upd_i <= (g == 2);
      rx_upd_i <= (g == 3);
      @(posedge mclk_i);
      {euler_upd_i, pos_upd_i, vel_upd_i, rx_upd_i} <= 4'h0;
      for (int i = 0; i < 20; i++) if (grp(i) == g) model[i] = expw(i, m);
   endtask

   // bus outputs idle after reset release, looked at mid-cycle
   task automatic idle_chk();
      @(negedge mclk_i);
      chk("idle flags", {23'h0, 9'h1c0}, {23'h0, s_axi_arready_o, s_axi_awready_o,
         s_axi_wready_o, s_axi_bvalid_o, s_axi_rvalid_o, s_axi_bresp_o, s_axi_rresp_o});
      chk("idle read data", ANR_WORD_RST, s_axi_rdata_o);
   endtask

   // read every word back to back against the model
   task automatic scan();
      for (int i = 0; i < 20; i++) begin
         HOST.rd({2'b00, rows[i].idx, 2'b00}, rd_d, rd_r);
         chk($sformatf("word %h", rows[i].idx), model[i], rd_d);
         chk("read response", {30'h0, ANR_RESP_OKAY}, {30'h0, rd_r});
      end
   endtask

   //==========================================================
   // clock and cycle ceiling
   initial begin
      mclk_i = 1'b0;
      forever #5 mclk_i = ~mclk_i;
   end

   always @(posedge mclk_i) begin
      cycles++;
      if (cycles == 20000) begin
         err_total++;
         end_of_test();
      end
   end

   //==========================================================
   // main sequence
   initial begin
      rows = '{'{8'h70, 32'h8123_0456, 32'h8123_0456}, '{8'h71, 32'hf789_5a5a, 32'hf789_0000},
         '{8'h72, 32'h0010_fff0, 32'h0010_fff0}, '{8'h73, 32'h7fff_a5a5, 32'h7fff_0000},
         '{8'h74, 32'h3f80_0000, 32'h3f80_0000}, '{8'h75, 32'h4120_0000, 32'h4120_0000},
         '{8'h76, 32'hc120_0000, 32'hc120_0000}, '{8'h77, 32'h42c8_0000, 32'h42c8_0000},
         '{8'h78, 32'h4000_0000, 32'h4000_0000}, '{8'h79, 32'h3f00_0000, 32'h3f00_0000},
         '{8'h7a, 32'hbf00_0000, 32'hbf00_0000}, '{8'h7b, 32'h3e80_0000, 32'h3e80_0000},
         '{8'h7c, 32'h4040_0000, 32'h4040_0000}, '{8'h7d, 32'h4228_0000, 32'h4228_0000},
         '{8'h7e, 32'hc2f0_0000, 32'hc2f0_0000}, '{8'h7f, 32'h4348_0000, 32'h4348_0000},
         '{8'h80, 32'h4334_0000, 32'h4334_0000}, '{8'h81, 32'h40a0_0000, 32'h40a0_0000},
         '{8'h82, 32'h4680_0400, 32'h4680_0400}, '{8'h83, 32'h0c2a_1f33, 32'h0c2a_1f33}};
      sys_rst_i = 1'b1;
      {euler_upd_i, pos_upd_i, vel_upd_i, rx_upd_i} = 4'h0;
      for (int i = 0; i < 20; i++) model[i] = ANR_WORD_RST;
      apply(32'h0);
      repeat (12) @(posedge mclk_i);
      sys_rst_i <= 1'b0;
      idle_chk();
      scan();
      for (int g = 0; g < 8; g++) begin
         pulse(g % 4, (g < 4) ? 32'h0 : 32'hffff_ffff);
         scan();
      end
      // writes leave data alone; unmapped write refused
      HOST.wr(12'h1c0, ~model[0], rd_r);
      chk("write response", {30'h0, ANR_RESP_OKAY}, {30'h0, rd_r});
      HOST.wr(12'h210, 32'h1234_5678, rd_r);
      chk("unmapped write response", {30'h0, ANR_RESP_SLVERR}, {30'h0, rd_r});
      HOST.rd(12'h1c0, rd_d, rd_r);
      chk("word 70 after write", model[0], rd_d);
      // reads outside the bank or unaligned
      foreach (bad[k]) begin
         HOST.rd(bad[k], rd_d, rd_r);
         chk("unmapped read data", 32'h0, rd_d);
         chk("unmapped read response", {30'h0, ANR_RESP_SLVERR}, {30'h0, rd_r});
      end
      // second reset in mid-run clears every word
      @(posedge mclk_i);
      sys_rst_i <= 1'b1;
      repeat (2) @(posedge mclk_i);
      sys_rst_i <= 1'b0;
      idle_chk();
      for (int i = 0; i < 20; i++) model[i] = ANR_WORD_RST;
      scan();
      end_of_test();
   end
endmodule
